// ### bench/ddof_checker.sv
module ddof_checker import ddof_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic par_prog,
	input wire logic [2:0] lvds_current_sel,
	input wire logic lvds_term_en,
	input wire logic [1:0] clk_phase_sel,
	input wire logic clk_invert,
	input wire ddof_code_t ch1_data_lines,
	input wire logic shared_overflow_out,
	input wire logic ch1_overflow_out,
	input wire logic ch2_overflow_out,
	input wire logic fwd_clock_true,
	input wire logic fwd_clock_comp,
	input wire logic ddr_mode_out,
	input wire logic [7:0] lvds_current_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// Edge timing only judged at zero shift; shifted clocks are measured by the bench
	logic ph0;
	assign ph0 = clk_phase_sel == 2'h0 && !clk_invert;
	sequence s_half;
		$stable(ch1_data_lines) [*3];
	endsequence
	sequence s_frame;
		s_half ##1 $stable(ch1_data_lines) [*4];
	endsequence
	a_clock_pair: assert property (fwd_clock_comp == !fwd_clock_true)
		else $error("forwarded clock lines not complementary");
	a_ddr_shared_of: assert property (ddr_mode_out |-> !ch1_overflow_out && !ch2_overflow_out)
		else $error("separate overflow active in double rate");
	a_full_sep_of: assert property (!ddr_mode_out |-> !shared_overflow_out)
		else $error("shared overflow active in full rate");
	a_ddr_upper_zero: assert property (ddr_mode_out |-> ch1_data_lines[13:7] == 7'h00)
		else $error("unused pair lines driven in double rate");
	a_current_plain: assert property (
		!par_prog && !lvds_term_en && lvds_current_sel == 3'h4 |=> lvds_current_out == 8'h46)
		else $error("driver current wrong");
	a_current_term: assert property (
		!par_prog && lvds_term_en && lvds_current_sel == 3'h0 |=> lvds_current_out == 8'h46)
		else $error("terminated driver current not doubled");
	a_full_fall_edge: assert property (
		!ddr_mode_out && ph0 && $changed(ch1_data_lines) |-> $fell(fwd_clock_true) ##1 s_frame)
		else $error("full rate data not aligned to clock fall");
	a_ddr_both_edge: assert property (
		ddr_mode_out && ph0 && $changed(ch1_data_lines) |-> $changed(fwd_clock_true) ##1 s_half)
		else $error("double rate data not aligned to clock edge");
endmodule : ddof_checker
bind ddof_top ddof_checker chk_u (.*);

// ### bench/ddof_rx_model.sv
module ddof_rx_model import ddof_pkg::*; (
	input wire logic core_clk,
	input wire logic ddr,
	input wire logic fwd,
	input wire ddof_code_t l1,
	input wire ddof_code_t l2,
	input wire logic sof,
	input wire logic of1,
	input wire logic of2,
	output ddof_word_s rx,
	output int words
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hist_reg = 3'h0;
	ddof_word_s acc = '0;
	initial rx = '0;
	initial words = 0;
	// Sampling three cycles after each clock edge lands inside the half at zero shift
	always @(posedge core_clk) begin
		hist_reg <= {hist_reg[1:0], fwd};
		if (hist_reg[2:1] == 2'h2 && ddr) begin
			for (int k = 0; k < 7; k++) begin
				acc.ch1_code[2*k] = l1[k];
				acc.ch2_code[2*k] = l2[k];
			end
			acc.ch1_of = sof;
		end
		if (hist_reg[2:1] == 2'h1) begin
			if (ddr) begin
				for (int k = 0; k < 7; k++) begin
					acc.ch1_code[2*k+1] = l1[k];
					acc.ch2_code[2*k+1] = l2[k];
				end
				acc.ch2_of = sof;
			end else
				acc = {of2, l2, of1, l1};
			rx <= acc;
			words <= words + 1;
		end
	end
endmodule : ddof_rx_model

// ### bench/dual_adc_ddr_output_formatter_test.sv
module dual_adc_ddr_output_formatter_test import ddof_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, enc_clk_pin = 1'b0, sample_valid = 1'b0;
	ddof_code_t ch1_code_in = 14'h0000, ch2_code_in = 14'h0000, ch1_data_lines, ch2_data_lines;
	logic ch1_over_in = 1'b0, ch1_under_in = 1'b0, ch2_over_in = 1'b0, ch2_under_in = 1'b0;
	logic [1:0] out_mode_sel = 2'h0, clk_phase_sel = 2'h0;
	logic par_prog = 1'b0, par_lvds_sel = 1'b0, lvds_term_en = 1'b0, dcs_en = 1'b1;
	logic clk_invert = 1'b0, twos_comp = 1'b0, sample_ready, shared_overflow_out;
	logic [2:0] lvds_current_sel = 3'h4;
	logic ch1_overflow_out, ch2_overflow_out, fwd_clock_true, fwd_clock_comp;
	logic lvds_mode_out, ddr_mode_out, lvds_term_out;
	logic [7:0] lvds_current_out;
	ddof_word_s rx;
	int words, mismatches = 0, n_tests = 0;
	always #10 core_clk = ~core_clk;
	always #80 enc_clk_pin = ~enc_clk_pin;
	ddof_top dut_u (.*);
	ddof_rx_model rx_u (.core_clk(core_clk), .ddr(ddr_mode_out), .fwd(fwd_clock_true),
		.l1(ch1_data_lines), .l2(ch2_data_lines), .sof(shared_overflow_out),
		.of1(ch1_overflow_out), .of2(ch2_overflow_out), .rx(rx), .words(words));
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic abort_run();
		mismatches++;
		give_verdict();
	endtask : abort_run
	task automatic cmp_w(input logic [29:0] got, input logic [29:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : cmp_w
	function automatic logic [14:0] xw(input ddof_code_t c, input logic [1:0] f, input logic t);
		ddof_code_t v;
		v = f[1] ? 14'h3FFF : (f[0] ? 14'h0000 : c);
		v[13] = v[13] ^ t;
		return {|f, v};
	endfunction : xw
	task automatic idle();
		@(negedge core_clk);
		sample_valid = 1'b0;
	endtask : idle
	// Valid stays up after the taking edge so back-to-back pushes need no gap
	task automatic push(input ddof_code_t a, input logic [1:0] fa, input ddof_code_t b,
		input logic [1:0] fb, output int w);
		@(negedge core_clk);
		ch1_code_in = a;
		{ch1_over_in, ch1_under_in} = fa;
		ch2_code_in = b;
		{ch2_over_in, ch2_under_in} = fb;
		sample_valid = 1'b1;
		for (w = 0; w < 99 && sample_ready !== 1'b1; w++)
			@(negedge core_clk);
		if (w == 99)
			abort_run();
		@(posedge core_clk);
	endtask : push
	task automatic wait_words(input int n);
		int s;
		s = words;
		for (int i = 0; i < 40 * n && words < s + n; i++)
			@(negedge core_clk);
		if (words < s + n)
			abort_run();
	endtask : wait_words
	task automatic wait_lines(input ddof_code_t v);
		for (int i = 0; i < 40 && ch1_data_lines !== v; i++)
			@(negedge core_clk);
		if (ch1_data_lines !== v)
			abort_run();
	endtask : wait_lines
	task automatic t_format();
		ddof_code_t c[3] = '{14'h1234, 14'h2000, 14'h0ABC};
		logic [1:0] f[3] = '{2'h0, 2'h2, 2'h1};
		int w;
		for (int m = 0; m < 4; m++) begin
			for (int t = 0; t < 2; t++) begin
				for (int j = 0; j < 3; j++) begin
					idle();
					out_mode_sel = m[1:0];
					twos_comp = t[0];
					push(c[j], f[j], ~c[j], f[(j + 1) % 3], w);
					idle();
					wait_words(3);
					cmp_w(rx, {xw(~c[j], f[(j + 1) % 3], t[0]), xw(c[j], f[j], t[0])});
					cmp_w({lvds_mode_out, ddr_mode_out}, m == 2 ? 2'h3 : (m == 1 ? 2'h1 : 2'h0));
				end
			end
		end
	endtask : t_format
	task automatic t_fifo();
		int w, full;
		full = 0;
		idle();
		out_mode_sel = 2'h0;
		twos_comp = 1'b0;
		for (int k = 1; k < 7; k++) begin
			push(14'h0111 * k, 2'h0, 14'h0222 * k, 2'h0, w);
			full += w;
		end
		idle();
		wait_words(9);
		cmp_w(full > 0, 1'b1);
		cmp_w(rx, {xw(14'h0CCC, 2'h0, 1'b0), xw(14'h0666, 2'h0, 1'b0)});
		cmp_w(sample_ready, 1'b1);
	endtask : t_fifo
	task automatic t_drive();
		logic [7:0] cur[8] = '{8'h23, 8'h2A, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h46};
		for (int i = 0; i < 16; i++) begin
			@(negedge core_clk);
			lvds_current_sel = i[2:0];
			lvds_term_en = i[3];
			repeat (2) @(negedge core_clk);
			cmp_w(lvds_current_out, cur[i[2:0]] << i[3]);
			cmp_w(lvds_term_out, i[3]);
		end
		par_prog = 1'b1;
		par_lvds_sel = 1'b1;
		out_mode_sel = 2'h1;
		repeat (20) @(negedge core_clk);
		cmp_w({lvds_mode_out, ddr_mode_out, lvds_current_out, lvds_term_out}, 11'h68C);
		par_lvds_sel = 1'b0;
		repeat (20) @(negedge core_clk);
		cmp_w({lvds_mode_out, ddr_mode_out}, 2'h0);
		par_prog = 1'b0;
		lvds_term_en = 1'b0;
		lvds_current_sel = 3'h4;
		// Freeze for two whole encode periods so the link keeps its alignment
		@(negedge core_clk);
		ce = 1'b0;
		lvds_current_sel = 3'h0;
		repeat (16) @(negedge core_clk);
		cmp_w(lvds_current_out, 8'h46);
		ce = 1'b1;
		lvds_current_sel = 3'h4;
	endtask : t_drive
	task automatic t_phase();
		int n;
		idle();
		out_mode_sel = 2'h1;
		push(14'h1555, 2'h0, 14'h0000, 2'h0, n);
		idle();
		for (int i = 0; i < 9; i++) begin
			clk_phase_sel = i == 8 ? 2'h2 : i[1:0];
			clk_invert = i[2];
			dcs_en = i < 8;
			repeat (24) @(negedge core_clk);
			wait_lines(14'h0000);
			wait_lines(14'h007F);
			for (n = 0; n < 8 && fwd_clock_true !== clk_invert; n++)
				@(negedge core_clk);
			cmp_w(n, i < 8 ? i % 4 : 0);
		end
	endtask : t_phase
	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		@(negedge core_clk);
		cmp_w({lvds_current_out, fwd_clock_comp}, 9'h08D);
		repeat (40) @(negedge core_clk);
		t_format();
		t_fifo();
		t_drive();
		t_phase();
		give_verdict();
	end
endmodule : dual_adc_ddr_output_formatter_test

// ### design/ddof_clkgen.sv
`include "ddof_map.svh"
module ddof_clkgen #(
	parameter int PERIOD_CYC = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic enc_clk_pin,
	input wire logic dcs_en,
	input wire logic [1:0] phase_sel,
	input wire logic clk_invert,
	output logic first_load,
	output logic second_load,
	output logic fwd_true,
	output logic fwd_comp
);
	localparam int CW = $clog2(PERIOD_CYC);
	localparam int STEP = PERIOD_CYC / `DDOF_PHASE_STEPS;
	localparam int HALF = PERIOD_CYC / 2;

	logic sync1_reg, sync2_reg, sync3_reg;
	logic [CW-1:0] cnt_reg, cnt_next, off, pos;
	logic true_reg, true_next, comp_reg, comp_next;
	logic [1:0] shift;

	always_comb begin
		if (sync2_reg && !sync3_reg) begin
			cnt_next = '0;
		end else if (cnt_reg == CW'(PERIOD_CYC - 1)) begin
			cnt_next = '0;
		end else begin
			cnt_next = CW'(cnt_reg + 1'b1);
		end
		// Phase shift needs a stable 50% internal clock to mean anything
		shift = dcs_en ? phase_sel : 2'b00;
		off = CW'(32'(shift) * STEP);
		if (cnt_next >= off) begin
			pos = CW'(cnt_next - off);
		end else begin
			pos = CW'(32'(cnt_next) + PERIOD_CYC - 32'(off));
		end
		// Unshifted clock falls as a sample is launched and rises at mid-period
		true_next = (pos >= CW'(HALF)) ^ clk_invert;
		comp_next = ~true_next;
		first_load = ce & (cnt_next == '0);
		second_load = ce & (cnt_next == CW'(HALF));
	end

	assign fwd_true = true_reg;
	// Own flop, so the pair leaves registers with no inverter skew between them
	assign fwd_comp = comp_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			cnt_reg <= '0;
			true_reg <= 1'b0;
			comp_reg <= 1'b1;
		end else if (ce) begin
			sync1_reg <= enc_clk_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			cnt_reg <= cnt_next;
			true_reg <= true_next;
			comp_reg <= comp_next;
		end
	end
endmodule : ddof_clkgen

// ### design/ddof_fifo.sv
module ddof_fifo #(
	parameter int W = 30,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	ddof_stream_if.snk wr,
	ddof_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("ddof_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [CW-1:0] count_reg, count_next;
	logic room_reg, room_next, empty_reg, empty_next;
	logic push, pop;

	assign wr.ready = room_reg;
	assign rd.valid = ~empty_reg;
	assign rd.data = mem[rptr_reg];

	always_comb begin
		push = ce & wr.valid & room_reg;
		pop = ce & rd.ready & ~empty_reg;
		wptr_next = push ? AW'(wptr_reg + 1'b1) : wptr_reg;
		rptr_next = pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
		count_next = count_reg;
		if (push && !pop) begin
			count_next = CW'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = CW'(count_reg - 1'b1);
		end
		room_next = (count_next != CW'(DEPTH));
		empty_next = (count_next == '0);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
			room_reg <= 1'b1;
			empty_reg <= 1'b1;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			count_reg <= count_next;
			room_reg <= room_next;
			empty_reg <= empty_next;
		end
	end

	// Storage holds no reset; only slots behind the write pointer are ever read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wptr_reg] <= wr.data;
		end
	end
endmodule : ddof_fifo

// ### design/ddof_map.svh
`ifndef DDOF_MAP_SVH
`define DDOF_MAP_SVH
// Contract
// - DDR CMOS: two bits per line each sample
// - DDR LVDS: seven pairs, pair k bits 2k,2k+1
// - DDR modes share one overflow output
// - Full rate: one overflow output per channel
// - LVDS current default 3.5mA, seven levels
// - Internal termination doubles the driver current
// - Overflow high when out of range
// - Overflow pipelined alongside its sample code
// - Full rate: data changes on clock fall
// - DDR: data changes on both clock edges
// - Clock phase shift 0/45/90/135 degrees
// - Phase shift only with stabiliser enabled
// - Clock invert independent of phase shift
// - Offset binary default, optional two's complement
// - Mode selectable; parallel path lacks DDR CMOS

`define DDOF_CORE_PERIOD_NS 20
`define DDOF_ENC_PERIOD_NS 160
`define DDOF_ENC_PERIOD_CYC (`DDOF_ENC_PERIOD_NS / `DDOF_CORE_PERIOD_NS)
`define DDOF_PHASE_STEPS 8
`define DDOF_FIFO_DEPTH 4
`define DDOF_CODE_W 14
`define DDOF_MSB 13
`define DDOF_FULL_SCALE 14'h3FFF
`define DDOF_ZERO_SCALE 14'h0000
`define DDOF_MIDSCALE 14'h2000
// LVDS current in units of 50 uA
`define DDOF_CUR_1P75 8'h23
`define DDOF_CUR_2P1 8'h2A
`define DDOF_CUR_2P5 8'h32
`define DDOF_CUR_3P0 8'h3C
`define DDOF_CUR_3P5 8'h46
`define DDOF_CUR_4P0 8'h50
`define DDOF_CUR_4P5 8'h5A
`define DDOF_CUR_RST `DDOF_CUR_3P5
`endif

// ### design/ddof_pkg.sv
`include "ddof_map.svh"
package ddof_pkg;
	typedef logic [`DDOF_CODE_W-1:0] ddof_code_t;
	typedef enum logic [1:0] {DDOF_FULL_CMOS, DDOF_DDR_CMOS, DDOF_DDR_LVDS} ddof_mode_e;
	typedef struct packed {
		logic ch2_of;
		ddof_code_t ch2_code;
		logic ch1_of;
		ddof_code_t ch1_code;
	} ddof_word_s;
endpackage : ddof_pkg

// ### design/ddof_stream_if.sv
interface ddof_stream_if #(parameter int W = 30) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : ddof_stream_if

// ### design/ddof_top.sv
`include "ddof_map.svh"
module ddof_top #(
	parameter int PERIOD_CYC = `DDOF_ENC_PERIOD_CYC,
	parameter int FIFO_DEPTH = `DDOF_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic enc_clk_pin,
	input wire logic sample_valid,
	input wire ddof_pkg::ddof_code_t ch1_code_in,
	input wire logic ch1_over_in,
	input wire logic ch1_under_in,
	input wire ddof_pkg::ddof_code_t ch2_code_in,
	input wire logic ch2_over_in,
	input wire logic ch2_under_in,
	input wire logic [1:0] out_mode_sel,
	input wire logic par_prog,
	input wire logic par_lvds_sel,
	input wire logic [2:0] lvds_current_sel,
	input wire logic lvds_term_en,
	input wire logic dcs_en,
	input wire logic [1:0] clk_phase_sel,
	input wire logic clk_invert,
	input wire logic twos_comp,
	output logic sample_ready,
	output ddof_pkg::ddof_code_t ch1_data_lines,
	output ddof_pkg::ddof_code_t ch2_data_lines,
	output logic shared_overflow_out,
	output logic ch1_overflow_out,
	output logic ch2_overflow_out,
	output logic fwd_clock_true,
	output logic fwd_clock_comp,
	output logic lvds_mode_out,
	output logic ddr_mode_out,
	output logic [7:0] lvds_current_out,
	output logic lvds_term_out
);
	import ddof_pkg::*;

	localparam int WW = $bits(ddof_word_s);

	if (PERIOD_CYC < `DDOF_PHASE_STEPS || (PERIOD_CYC % `DDOF_PHASE_STEPS) != 0) begin : g_chk_p
		$error("ddof_top: PERIOD_CYC must be a nonzero multiple of the phase step count");
	end
	if (FIFO_DEPTH < 2) begin : g_chk_d
		$error("ddof_top: FIFO_DEPTH must be at least 2");
	end

	// Clamp, flag and encode one channel; result is {overflow, code}
	function automatic logic [`DDOF_CODE_W:0] fmt_channel(input ddof_code_t code,
		input logic over, input logic under, input logic twos);
		ddof_code_t c;
		c = code;
		if (over) begin
			c = `DDOF_FULL_SCALE;
		end else if (under) begin
			c = `DDOF_ZERO_SCALE;
		end
		// Mid-scale sits at the MSB alone, so flipping it yields two's complement
		c[`DDOF_MSB] = c[`DDOF_MSB] ^ twos;
		return {over | under, c};
	endfunction : fmt_channel

	function automatic logic [6:0] even_bits(input ddof_code_t code);
		logic [6:0] r;
		r = '0;
		for (int k = 0; k < 7; k++) begin
			r[k] = code[2 * k];
		end
		return r;
	endfunction : even_bits

	function automatic logic [6:0] odd_bits(input ddof_code_t code);
		logic [6:0] r;
		r = '0;
		for (int k = 0; k < 7; k++) begin
			r[k] = code[2 * k + 1];
		end
		return r;
	endfunction : odd_bits

	function automatic logic [7:0] current_lookup(input logic [2:0] sel);
		logic [7:0] r;
		case (sel)
			3'h0: r = `DDOF_CUR_1P75;
			3'h1: r = `DDOF_CUR_2P1;
			3'h2: r = `DDOF_CUR_2P5;
			3'h3: r = `DDOF_CUR_3P0;
			3'h4: r = `DDOF_CUR_3P5;
			3'h5: r = `DDOF_CUR_4P0;
			3'h6: r = `DDOF_CUR_4P5;
			default: r = `DDOF_CUR_RST;
		endcase
		return r;
	endfunction : current_lookup

	ddof_stream_if #(.W(WW)) in_s ();
	ddof_stream_if #(.W(WW)) out_s ();

	logic first_load, second_load;
	logic [`DDOF_CODE_W:0] f1, f2;
	ddof_word_s w;
	ddof_mode_e req_mode;
	logic [7:0] base_cur;

	ddof_word_s cur_reg, cur_next;
	ddof_mode_e mode_reg, mode_next;
	ddof_code_t l1_reg, l1_next, l2_reg, l2_next;
	logic sh_of_reg, sh_of_next, of1_reg, of1_next, of2_reg, of2_next;
	logic lvds_reg, lvds_next, ddr_reg, ddr_next;
	logic [7:0] cur_drv_reg, cur_drv_next;
	logic term_reg, term_next;

	// Flags ride in the same FIFO word as their codes
	always_comb begin
		f1 = fmt_channel(ch1_code_in, ch1_over_in, ch1_under_in, twos_comp);
		f2 = fmt_channel(ch2_code_in, ch2_over_in, ch2_under_in, twos_comp);
		in_s.data = {f2, f1};
		in_s.valid = sample_valid;
	end

	assign sample_ready = in_s.ready;
	assign out_s.ready = first_load;

	ddof_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.wr(in_s),
		.rd(out_s)
	);

	ddof_clkgen #(.PERIOD_CYC(PERIOD_CYC)) u_clkgen (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.enc_clk_pin(enc_clk_pin),
		.dcs_en(dcs_en),
		.phase_sel(clk_phase_sel),
		.clk_invert(clk_invert),
		.first_load(first_load),
		.second_load(second_load),
		.fwd_true(fwd_clock_true),
		.fwd_comp(fwd_clock_comp)
	);

	always_comb begin
		// Pin-strapped path offers only full rate CMOS or DDR LVDS
		if (par_prog) begin
			req_mode = par_lvds_sel ? DDOF_DDR_LVDS : DDOF_FULL_CMOS;
		end else begin
			case (out_mode_sel)
				2'h1: req_mode = DDOF_DDR_CMOS;
				2'h2: req_mode = DDOF_DDR_LVDS;
				default: req_mode = DDOF_FULL_CMOS;
			endcase
		end
	end

	always_comb begin
		cur_next = cur_reg;
		mode_next = mode_reg;
		l1_next = l1_reg;
		l2_next = l2_reg;
		sh_of_next = sh_of_reg;
		of1_next = of1_reg;
		of2_next = of2_reg;
		lvds_next = lvds_reg;
		ddr_next = ddr_reg;
		// An underrun repeats the last sample rather than stalling the link
		w = out_s.valid ? ddof_word_s'(out_s.data) : cur_reg;
		// Strapped LVDS runs at default current with termination off
		base_cur = par_prog ? `DDOF_CUR_RST : current_lookup(lvds_current_sel);
		term_next = ~par_prog & lvds_term_en;
		cur_drv_next = term_next ? {base_cur[6:0], 1'b0} : base_cur;
		if (first_load) begin
			// Mode changes only on a sample boundary so no half-sample is sent
			cur_next = w;
			mode_next = req_mode;
			lvds_next = (req_mode == DDOF_DDR_LVDS);
			ddr_next = (req_mode != DDOF_FULL_CMOS);
			if (req_mode == DDOF_FULL_CMOS) begin
				l1_next = w.ch1_code;
				l2_next = w.ch2_code;
				of1_next = w.ch1_of;
				of2_next = w.ch2_of;
				sh_of_next = 1'b0;
			end else begin
				l1_next = {7'h00, even_bits(w.ch1_code)};
				l2_next = {7'h00, even_bits(w.ch2_code)};
				sh_of_next = w.ch1_of;
				of1_next = 1'b0;
				of2_next = 1'b0;
			end
		end else if (second_load && mode_reg != DDOF_FULL_CMOS) begin
			l1_next = {7'h00, odd_bits(cur_reg.ch1_code)};
			l2_next = {7'h00, odd_bits(cur_reg.ch2_code)};
			sh_of_next = cur_reg.ch2_of;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cur_reg <= '0;
			mode_reg <= DDOF_FULL_CMOS;
			l1_reg <= '0;
			l2_reg <= '0;
			sh_of_reg <= 1'b0;
			of1_reg <= 1'b0;
			of2_reg <= 1'b0;
			lvds_reg <= 1'b0;
			ddr_reg <= 1'b0;
			cur_drv_reg <= `DDOF_CUR_RST;
			term_reg <= 1'b0;
		end else if (ce) begin
			cur_reg <= cur_next;
			mode_reg <= mode_next;
			l1_reg <= l1_next;
			l2_reg <= l2_next;
			sh_of_reg <= sh_of_next;
			of1_reg <= of1_next;
			of2_reg <= of2_next;
			lvds_reg <= lvds_next;
			ddr_reg <= ddr_next;
			cur_drv_reg <= cur_drv_next;
			term_reg <= term_next;
		end
	end

	assign ch1_data_lines = l1_reg;
	assign ch2_data_lines = l2_reg;
	assign shared_overflow_out = sh_of_reg;
	assign ch1_overflow_out = of1_reg;
	assign ch2_overflow_out = of2_reg;
	assign lvds_mode_out = lvds_reg;
	assign ddr_mode_out = ddr_reg;
	assign lvds_current_out = cur_drv_reg;
	assign lvds_term_out = term_reg;
endmodule : ddof_top
